// ==== verilog/efc_pkg.sv ====
package efc_pkg;
   ////////////////////////////////////////////////////////////////////////////////
   // Register map
   localparam logic [7:0] EFC_ENH_CFG_OFFSET = 8'h45;
   localparam logic [7:0] EFC_ENH_CFG_RESET  = 8'h00;
   localparam int         EFC_BIT_FILT       = 6;
   localparam int         EFC_BIT_TABLE_RES  = 5;
   localparam int         EFC_BIT_HRES       = 4;
   localparam int         EFC_BIT_UNSIGNED   = 3;
   localparam int         EFC_BIT_RATE_HI    = 2;
   localparam int         EFC_BIT_RATE_LO    = 1;
   localparam int         EFC_BIT_SMOOTH     = 0;
   localparam int         EFC_LSB_FRAC_HI    = 4;
   localparam int         EFC_LSB_FRAC_LO    = 3;
   localparam logic [7:0] EFC_READ_NONE      = 8'h00;
   localparam logic [7:0] EFC_LSB_RESET      = 8'h00;
   localparam logic [7:0] EFC_DUTY_RESET     = 8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // Duty steps in 1/256 units: 0.39% and 6.25%
   localparam logic [8:0] EFC_STEP_FINE      = 9'h001;
   localparam logic [8:0] EFC_STEP_COARSE    = 9'h010;
   localparam logic [7:0] EFC_COARSE_MASK    = 8'hF0;

   ////////////////////////////////////////////////////////////////////////////////
   // Ramp intervals per step, in ns as printed, and cycles at 4 ns
   localparam longint EFC_CLK_PERIOD_NS = 4;
   localparam longint EFC_RAMP0_NS      = 64'd23_000_000;
   localparam longint EFC_RAMP1_NS      = 64'd46_000_000;
   localparam longint EFC_RAMP2_NS      = 64'd910_000_000;
   localparam longint EFC_RAMP3_NS      = 64'd182_000_000;
   localparam int     EFC_RAMP0_CYC     = int'(EFC_RAMP0_NS / EFC_CLK_PERIOD_NS);
   localparam int     EFC_RAMP1_CYC     = int'(EFC_RAMP1_NS / EFC_CLK_PERIOD_NS);
   localparam int     EFC_RAMP2_CYC     = int'(EFC_RAMP2_NS / EFC_CLK_PERIOD_NS);
   localparam int     EFC_RAMP3_CYC     = int'(EFC_RAMP3_NS / EFC_CLK_PERIOD_NS);
   localparam int     EFC_CNT_W         = 28;

   ////////////////////////////////////////////////////////////////////////////////
   // Enhanced configuration fields
   typedef struct packed {
      logic       filter_fraction_bits_enable;
      logic       table_temp_resolution_ext;
      logic       duty_high_resolution;
      logic       setpoint_unsigned_format;
      logic [1:0] smoothing_ramp_rate;
      logic       smoothing_enable;
   } efc_cfg_t;

   localparam efc_cfg_t EFC_CFG_RESET = efc_cfg_t'(EFC_ENH_CFG_RESET[6:0]);

   // Duty source seen by the fan path
   typedef struct packed {
      logic       forced;
      logic [7:0] forced_duty;
      logic [7:0] table_duty;
   } efc_duty_req_t;
endpackage : efc_pkg

// ==== verilog/efc_ramp_timer.sv ====
module efc_ramp_timer
   import efc_pkg::*;
#(
   parameter int unsigned P_CYC0 = EFC_RAMP0_CYC,
   parameter int unsigned P_CYC1 = EFC_RAMP1_CYC,
   parameter int unsigned P_CYC2 = EFC_RAMP2_CYC,
   parameter int unsigned P_CYC3 = EFC_RAMP3_CYC
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       run,
   input  wire logic [1:0] rate,
   output logic            tick
);
   logic [EFC_CNT_W-1:0] cnt_r;
   logic [EFC_CNT_W-1:0] limit;

   function automatic logic [EFC_CNT_W-1:0] ramp_limit(input logic [1:0] sel);
      case (sel)
         2'h0:    ramp_limit = EFC_CNT_W'(P_CYC0 - 1);
         2'h1:    ramp_limit = EFC_CNT_W'(P_CYC1 - 1);
         2'h2:    ramp_limit = EFC_CNT_W'(P_CYC2 - 1);
         default: ramp_limit = EFC_CNT_W'(P_CYC3 - 1);
      endcase
   endfunction

   assign limit = ramp_limit(rate);
   assign tick  = run && (cnt_r >= limit);

   // Interval restarts whenever smoothing is not running
   always_ff @(posedge clk) begin
      if (rst || !run || tick) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + EFC_CNT_W'(1);
      end
   end
endmodule // efc_ramp_timer

// ==== verilog/efc_top.sv ====
module efc_top
   import efc_pkg::*;
#(
   parameter int unsigned P_RAMP0_CYC = EFC_RAMP0_CYC,
   parameter int unsigned P_RAMP1_CYC = EFC_RAMP1_CYC,
   parameter int unsigned P_RAMP2_CYC = EFC_RAMP2_CYC,
   parameter int unsigned P_RAMP3_CYC = EFC_RAMP3_CYC
) (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic [7:0]    reg_addr,
   input  wire logic          reg_wr,
   input  wire logic [7:0]    reg_wdata,
   input  wire logic          reg_rd,
   output logic [7:0]         reg_rdata,
   input  wire logic          pwm_programming_enable,
   input  wire logic          pwm_freq_22k5,
   input  wire logic          remote_filter_active,
   input  wire logic [7:0]    remote_lsb_raw,
   output logic [7:0]         remote_lsb,
   input  wire logic          spinup_active,
   input  wire efc_duty_req_t duty_req,
   output logic [7:0]         duty,
   output logic               table_temp_resolution_ext,
   output logic               duty_fine_steps,
   output logic               setpoint_unsigned_format
);
   ////////////////////////////////////////////////////////////////////////////////
   // Register
   efc_cfg_t   cfg_r;
   logic [7:0] rdata_r;
   logic [7:0] lsb_r;
   logic [7:0] duty_r;
   logic       hit_wr;
   logic       fine;
   logic       smooth_on;
   logic       tick;
   logic [7:0] target;
   logic [8:0] step;
   logic [7:0] duty_nxt;

   assign hit_wr = reg_wr && (reg_addr == EFC_ENH_CFG_OFFSET);

   always_ff @(posedge clk) begin
      if (rst) begin
         cfg_r <= EFC_CFG_RESET;
      end else if (hit_wr) begin
         cfg_r.filter_fraction_bits_enable <= reg_wdata[EFC_BIT_FILT];
         cfg_r.table_temp_resolution_ext   <= reg_wdata[EFC_BIT_TABLE_RES];
         cfg_r.duty_high_resolution        <= reg_wdata[EFC_BIT_HRES];
         cfg_r.setpoint_unsigned_format    <= reg_wdata[EFC_BIT_UNSIGNED];
         if (pwm_programming_enable) begin
            cfg_r.smoothing_ramp_rate <= reg_wdata[EFC_BIT_RATE_HI:EFC_BIT_RATE_LO];
            cfg_r.smoothing_enable    <= reg_wdata[EFC_BIT_SMOOTH];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_r <= EFC_READ_NONE;
      end else if (reg_rd) begin
         rdata_r <= (reg_addr == EFC_ENH_CFG_OFFSET) ? {1'b0, cfg_r} : EFC_READ_NONE;
      end
   end

   assign reg_rdata = rdata_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Remote temperature low byte
   // fraction bit masking
   always_ff @(posedge clk) begin
      if (rst) begin
         lsb_r <= EFC_LSB_RESET;
      end else begin
         lsb_r <= remote_lsb_raw;
         if (!(cfg_r.filter_fraction_bits_enable && remote_filter_active)) begin
            lsb_r[EFC_LSB_FRAC_HI:EFC_LSB_FRAC_LO] <= 2'h0;
         end
      end
   end

   assign remote_lsb = lsb_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Mode outputs
   // table and setpoint modes
   assign table_temp_resolution_ext = cfg_r.table_temp_resolution_ext;
   assign setpoint_unsigned_format  = cfg_r.setpoint_unsigned_format;
   assign fine            = cfg_r.duty_high_resolution && pwm_freq_22k5;
   assign duty_fine_steps = fine;

   ////////////////////////////////////////////////////////////////////////////////
   // Duty smoothing
   // smoothing qualifiers
   assign smooth_on = cfg_r.smoothing_enable && pwm_freq_22k5 && !spinup_active
                      && !duty_req.forced;
   assign target    = fine ? duty_req.table_duty : (duty_req.table_duty & EFC_COARSE_MASK);
   assign step      = fine ? EFC_STEP_FINE : EFC_STEP_COARSE;

   efc_ramp_timer #(
      .P_CYC0 (P_RAMP0_CYC),
      .P_CYC1 (P_RAMP1_CYC),
      .P_CYC2 (P_RAMP2_CYC),
      .P_CYC3 (P_RAMP3_CYC)
   ) efc_ramp_timer_inst (
      .clk  (clk),
      .rst  (rst),
      .run  (smooth_on && (duty_r != target)),
      .rate (cfg_r.smoothing_ramp_rate),
      .tick (tick)
   );

   always_comb begin
      duty_nxt = duty_r;
      if (duty_r < target) begin
         duty_nxt = ({1'b0, duty_r} + step > {1'b0, target}) ? target
                    : 8'({1'b0, duty_r} + step);
      end else if (duty_r > target) begin
         duty_nxt = ({1'b0, target} + step > {1'b0, duty_r}) ? target
                    : 8'({1'b0, duty_r} - step);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         duty_r <= EFC_DUTY_RESET;
      end else if (duty_req.forced) begin
         duty_r <= duty_req.forced_duty;
      end else if (!smooth_on) begin
         duty_r <= target;
      end else if (tick) begin
         duty_r <= duty_nxt;
      end
   end

   assign duty = duty_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_cfg_write_locked;
      hit_wr && !pwm_programming_enable;
   endsequence

   sequence s_cfg_write_open;
      hit_wr && pwm_programming_enable;
   endsequence

   AST_TOP_BIT_ZERO: assert property (@(posedge clk) disable iff (rst)
      reg_rd |=> reg_rdata[7] == 1'b0)
      else $error("Top bit read as one");

   AST_FRAC_MASKED: assert property (@(posedge clk) disable iff (rst)
      !cfg_r.filter_fraction_bits_enable |=> remote_lsb[4:3] == 2'h0)
      else $error("Fraction bits not masked");

   AST_FRAC_PASSED: assert property (@(posedge clk) disable iff (rst)
      cfg_r.filter_fraction_bits_enable && remote_filter_active
      |=> remote_lsb == $past(remote_lsb_raw))
      else $error("Fraction bits not reported");

   AST_LOCKED_WRITE: assert property (@(posedge clk) disable iff (rst)
      s_cfg_write_locked |=> $stable(cfg_r[2:0]))
      else $error("Smoothing fields changed while locked");

   AST_OPEN_WRITE: assert property (@(posedge clk) disable iff (rst)
      s_cfg_write_open |=> cfg_r[2:0] == $past(reg_wdata[2:0]))
      else $error("Smoothing fields not written");

   AST_FORCED_DUTY: assert property (@(posedge clk) disable iff (rst)
      duty_req.forced |=> duty == $past(duty_req.forced_duty))
      else $error("Forced duty not applied");

   AST_NO_SMOOTH_OFF_FREQ: assert property (@(posedge clk) disable iff (rst)
      !pwm_freq_22k5 && !duty_req.forced
      |=> duty == ($past(duty_req.table_duty) & EFC_COARSE_MASK))
      else $error("Duty not following table off 22.5kHz");

   AST_RAMP_ONE_STEP: assert property (@(posedge clk) disable iff (rst)
      smooth_on && !tick |=> $stable(duty))
      else $error("Duty moved between ramp ticks");

   AST_RESET_CLEAR: assert property (@(posedge clk)
      rst |=> cfg_r == EFC_CFG_RESET && duty == 8'h00)
      else $error("Reset did not clear state");

   sequence s_ramp_tick;
      smooth_on && tick;
   endsequence

   AST_TICK_MOVES: assert property (@(posedge clk) disable iff (rst)
      s_ramp_tick |=> duty != $past(duty))
      else $error("Duty did not step on ramp tick");

   AST_SPINUP_NO_RAMP: assert property (@(posedge clk) disable iff (rst)
      spinup_active && !duty_req.forced |=> duty == $past(target))
      else $error("Duty ramped during spin-up");

   AST_FINE_NEEDS_FREQ: assert property (@(posedge clk) disable iff (rst)
      !pwm_freq_22k5 |-> !duty_fine_steps)
      else $error("Fine steps outside 22.5kHz");
endmodule // efc_top

// ==== verification/test_enhanced_fan_config.sv ====
module test_enhanced_fan_config
   import efc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PR [4] = '{4, 8, 16, 12};
   logic          clk = 1'b0;
   logic          rst = 1'b1;
   logic [7:0]    reg_addr = 8'h00;
   logic          reg_wr = 1'b0;
   logic [7:0]    reg_wdata = 8'h00;
   logic          reg_rd = 1'b0;
   logic [7:0]    reg_rdata;
   logic          prog = 1'b1;
   logic          freq = 1'b1;
   logic          filt = 1'b0;
   logic [7:0]    raw = 8'h00;
   logic [7:0]    remote_lsb;
   logic          spin = 1'b0;
   efc_duty_req_t dreq = '0;
   logic [7:0]    duty;
   logic          tres;
   logic          fine;
   logic          unsg;
   logic [31:0]   seed = 32'h0000_0061;
   logic [7:0]    meas, e, g, prev, t;
   logic [7:0]    exp_q [$];
   int            sel_q [$];
   int            errors = 0;
   int            compares = 0;
   int            cycles = 0;
   int            s, cnt, steps;
   event          note_ev;

   efc_top #(.P_RAMP0_CYC(4), .P_RAMP1_CYC(8), .P_RAMP2_CYC(16), .P_RAMP3_CYC(12)) efc_top_inst (
      .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_programming_enable(prog),
      .pwm_freq_22k5(freq), .remote_filter_active(filt), .remote_lsb_raw(raw),
      .remote_lsb(remote_lsb), .spinup_active(spin), .duty_req(dreq), .duty(duty),
      .table_temp_resolution_ext(tres), .duty_fine_steps(fine),
      .setpoint_unsigned_format(unsg));

   always #2 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////////
   // Expectation queue and watcher
   function automatic logic [7:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction

   function automatic logic [7:0] got(input int k);
      case (k)
         0: return reg_rdata;
         1: return remote_lsb;
         2: return duty;
         3: return {7'h00, fine};
         4: return {7'h00, tres};
         5: return {7'h00, unsg};
         default: return meas;
      endcase
   endfunction

   task automatic note(input logic [7:0] x, input int k);
      exp_q.push_back(x);
      sel_q.push_back(k);
      -> note_ev;
   endtask

   always begin
      @(note_ev);
      while (exp_q.size() > 0) begin
         e = exp_q.pop_front();
         s = sel_q.pop_front();
         g = got(s);
         compares++;
         if (g !== e) begin
            errors++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
         end
      end
   end

   task automatic end_sim();
      $display("compares=%0d errors=%0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         end_sim();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register bus and ramp tasks
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      @(negedge clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      note(x, 0);
      @(negedge clk);
   endtask

   task automatic ramp(input int r, input logic f, input logic [7:0] tg, input int n);
      freq = 1'b1;
      dreq.table_duty = 8'h00;
      wr(8'h45, 8'h00);
      wr(8'h45, {3'b000, f, 1'b0, r[1:0], 1'b1});
      dreq.table_duty = tg;
      cnt = 0;
      steps = 0;
      prev = duty;
      for (int k = 0; k < (n + 2) * PR[r] && steps < n; k++) begin
         @(negedge clk);
         cnt++;
         if (duty !== prev) begin
            meas = 8'(cnt);
            note(prev + (f ? 8'h01 : 8'h10), 2);
            if (steps > 0) note(8'(PR[r]), 6);
            prev = duty;
            cnt = 0;
            steps++;
         end
      end
      note(tg, 2);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (8) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      rd(8'h45, 8'h00);
      note(8'h00, 4);
      note(8'h00, 5);
      wr(8'h45, 8'hFF);
      rd(8'h45, 8'h7F);
      note(8'h01, 3);
      note(8'h01, 4);
      note(8'h01, 5);
      @(negedge clk);
      freq = 1'b0;
      @(negedge clk);
      note(8'h00, 3);
      @(negedge clk);
      freq = 1'b1;
      prog = 1'b0;
      wr(8'h45, 8'h00);
      rd(8'h45, 8'h07);
      note(8'h00, 4);
      note(8'h00, 5);
      prog = 1'b1;
      wr(8'h45, 8'h00);
      rd(8'h45, 8'h00);
      rd(8'h44, 8'h00);
      $display("done: registers");
      for (int i = 0; i < 4; i++) begin
         wr(8'h45, {1'b0, i[1], 6'h00});
         filt = i[0];
         t = xs() | 8'h18;
         raw = t;
         @(negedge clk);
         note((i == 3) ? t : (t & 8'hE7), 1);
      end
      $display("done: remote fraction");
      wr(8'h45, 8'h10);
      t = xs() | 8'h01;
      dreq.table_duty = t;
      @(negedge clk);
      note(t, 2);
      wr(8'h45, 8'h00);
      note(t & 8'hF0, 2);
      dreq.forced = 1'b1;
      t = xs() | 8'h05;
      dreq.forced_duty = t;
      @(negedge clk);
      note(t, 2);
      dreq.forced = 1'b0;
      $display("done: duty jumps");
      for (int r = 0; r < 4; r++) ramp(r, 1'b1, 8'h03, 3);
      ramp(0, 1'b0, 8'h40, 4);
      $display("done: smoothing");
      spin = 1'b1;
      dreq.table_duty = 8'h80;
      @(negedge clk);
      note(8'h80, 2);
      spin = 1'b0;
      freq = 1'b0;
      wr(8'h45, 8'h11);
      dreq.table_duty = 8'h37;
      @(negedge clk);
      note(8'h30, 2);
      $display("done: suppression");
      rst = 1'b1;
      repeat (2) @(negedge clk);
      note(8'h00, 2);
      note(8'h00, 1);
      rst = 1'b0;
      @(negedge clk);
      rd(8'h45, 8'h00);
      $display("done: reset");
      end_sim();
   end
endmodule // test_enhanced_fan_config
